//--- hw/rcas_commutation.sv
`timescale 1ns/1ps
// How it works
// [RL1] Source field: 0 zero angle, 1 resolver, 2 encoder.
// [RL2] Zero source holds feedback angle at exactly zero.
// [RL3] Resolver mode takes resolver angle, 16 bits per revolution.
// [RL4] Encoder mode takes encoder angle, 16 bits per revolution.
// [RL5] Signed 16-bit trim added for every source, reset 5461.
// [RL6] Commutation angle built from pole count and measured angle.
// [RL7] Software selects sensor, torque mode 1301, then writes request 1.
// [RL8] Measurement starts when drive enables while request holds 1.
// [RL9] About two seconds later request clears, measured trim remains.
// [RL10] Auto UVW flag on supporting build: angle from tracks at power up.
// [RL11] Auto UVW off: no motion enable until measurement completed; here also enabled while request is 1 or measurement runs.
// [RL12] UVW to sinusoidal: change, Z-marker, change then Z, bus signal.
// [RL13] Current mode, UVW or sinusoidal, readable in status.
// [RL14] Tracks sampled once every two milliseconds.
// [RL15] Software sets velocity limit so tracks can keep up.
// [RL16] Measurement also yields Z-marker offset in electrical degrees.
// [RL17] Position loop source: 1 resolver, 2 encoder, reset resolver.
// [RL18] Track pattern: U bit 0, V bit 1, W bit 2.
// [RL19] Electrical angle = mechanical times pole pairs plus trim, wrapping.
// [RL20] Source writes outside 0 to 2 are ignored.
module rcas_commutation #(
   parameter int unsigned TRACK_CYCLES = rcas_pkg::TRACK_SAMPLE_CYCLES,
   parameter int unsigned MEAS_CYCLES = rcas_pkg::OFFSET_MEAS_CYCLES,
   parameter bit UVW_SUPPORTED = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [rcas_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [rcas_pkg::REG_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [rcas_pkg::REG_DATA_W-1:0] regRdData,
   // Sensor front end
   input wire logic [15:0] resolverAngle,
   input wire logic [15:0] encoderAngle,
   input wire logic [2:0] trackUvw,
   input wire logic zMarker,
   // Drive
   input wire logic driveEnable,
   output logic motionEnable,
   output logic uvwActive,
   output logic [15:0] feedbackAngle,
   output logic [15:0] phaseAngle,
   output logic [15:0] positionFeedback
);
   import rcas_pkg::*;

   localparam int MEAS_W = $clog2(MEAS_CYCLES);

   typedef enum {MS_IDLE, MS_RUN} rcas_meas_e;
   typedef enum {CM_INIT, CM_UVW, CM_SINUS} rcas_comm_e;

   // ****************************************
   // Declarations
   // ****************************************
   logic [7:0] angleSource;
   logic [15:0] trim;
   logic [7:0] trimRequest;
   logic [31:0] loopType;
   logic [15:0] poleCount;
   logic [7:0] posSource;
   logic autoUvw;
   logic [2:0] switchMode;
   logic [2:0] zeroPattern;
   logic offsetValid;
   logic zRefValid;
   logic [15:0] zRefAngle;
   logic [8:0] zOffsetDeg;
   rcas_meas_e measState;
   rcas_comm_e commState;
   logic [MEAS_W-1:0] measCount;
   logic enablePrev;
   logic busSwitch;

   logic wrSource, wrTrim, wrRequest, pole_count_write, wrUvw;
   logic measStart, measDone;
   logic [2:0] track;
   logic trackValid, trackChange;
   logic [15:0] mechAngle, polePairs, rawElec, sectorStart, uvwAngle;
   logic [31:0] elecProduct;
   logic [3:0] sectorSum;
   logic [2:0] sectorRel;
   logic [15:0] zAngle;
   logic [24:0] degProduct;
   logic toSinus, zRefresh;
   logic [15:0] next_phaseAngle;

   // ****************************************
   // Helpers
   // ****************************************
   // Position of a track pattern along the rotation sequence
   function automatic logic [2:0] track_pos(input logic [2:0] pattern);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 0; i < SECTORS; i++) begin
         if (pattern == UVW_SEQ[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : track_pos

   function automatic logic is_write(input logic [REG_ADDR_W-1:0] addr,
                                     input logic [REG_ADDR_W-1:0] target,
                                     input logic strobe);
      return strobe && (addr == target);
   endfunction : is_write

   assign wrSource = is_write(regAddr, ADDR_ANGLE_SOURCE, regWrite);
   assign wrTrim = is_write(regAddr, ADDR_TRIM, regWrite);
   assign wrRequest = is_write(regAddr, ADDR_TRIM_REQUEST, regWrite);
   assign pole_count_write = is_write(regAddr, ADDR_POLE_COUNT, regWrite);
   assign wrUvw = is_write(regAddr, ADDR_UVW_CTRL, regWrite);

   // ****************************************
   // Track sampling
   // ****************************************
   rcas_track_sampler #(
      .PERIOD(TRACK_CYCLES)
   ) trackSampler (
      .clk(clk),
      .sys_rst(sys_rst),
      .trackIn(trackUvw),
      .sample(track),
      .sampleValid(trackValid),
      .trackChange(trackChange)
   ); // see [RL14]

   // ****************************************
   // Angle arithmetic
   // ****************************************
   always_comb begin
      case (angleSource)
         SOURCE_RESOLVER: mechAngle = resolverAngle; // see [RL3]
         SOURCE_ENCODER: mechAngle = encoderAngle; // see [RL4]
         default: mechAngle = 16'h0000; // see [RL2]
      endcase
   end

   assign polePairs = poleCount >> 1;
   assign elecProduct = mechAngle * polePairs; // see [RL6]
   assign rawElec = elecProduct[15:0]; // see [RL19]

   // Sector relative to the zero-degree pattern
   assign sectorSum = 4'(track_pos(track)) + 4'(SECTORS) - 4'(track_pos(zeroPattern)); // see [RL18]
   assign sectorRel = (sectorSum >= 4'(SECTORS)) ? 3'(sectorSum - 4'(SECTORS)) : sectorSum[2:0];
   assign sectorStart = 16'(sectorRel * SECTOR_STEP);
   assign uvwAngle = sectorStart + HALF_SECTOR;

   assign zAngle = rawElec + trim;
   assign degProduct = 25'(zAngle) * DEG_FULL;

   always_comb begin
      if (measState == MS_RUN) begin
         next_phaseAngle = 16'h0000;
      end else if (commState == CM_UVW) begin
         next_phaseAngle = uvwAngle; // see [RL10]
      end else begin
         next_phaseAngle = rawElec + trim; // see [RL5] [RL19]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         feedbackAngle <= 16'h0000;
         phaseAngle <= 16'h0000;
      end else begin
         feedbackAngle <= mechAngle; // see [RL2]
         phaseAngle <= next_phaseAngle;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         positionFeedback <= 16'h0000;
      end else begin
         positionFeedback <= (posSource == POS_ENCODER) ? encoderAngle : resolverAngle; // see [RL17]
      end
   end

   // ****************************************
   // Offset measurement
   // ****************************************
   assign measStart = (measState == MS_IDLE) && (trimRequest == TRIM_REQUEST_ON)
                      && driveEnable && !enablePrev; // see [RL8]
   assign measDone = (measState == MS_RUN) && driveEnable
                     && (measCount == MEAS_W'(MEAS_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enablePrev <= 1'b0;
      end else begin
         enablePrev <= driveEnable;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         measState <= MS_IDLE;
         measCount <= '0;
      end else begin
         case (measState)
            MS_IDLE: begin
               measCount <= '0;
               if (measStart) begin
                  measState <= MS_RUN;
               end
            end
            MS_RUN: begin
               measCount <= measCount + 1'b1;
               if (!driveEnable || measDone) begin
                  measState <= MS_IDLE;
               end
            end
            default: measState <= MS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         offsetValid <= 1'b0;
      end else if (measDone) begin
         offsetValid <= 1'b1;
      end
   end

   // ****************************************
   // Commutation mode
   // ****************************************
   always_comb begin
      case (switchMode)
         SWITCH_AT_CHANGE, SWITCH_CHANGE_Z: toSinus = trackChange;
         SWITCH_AT_Z: toSinus = zMarker && zRefValid;
         SWITCH_BY_BUS: toSinus = busSwitch;
         default: toSinus = 1'b0;
      endcase
   end

   assign zRefresh = zMarker && zRefValid && (commState == CM_SINUS)
                     && (switchMode == SWITCH_CHANGE_Z);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         commState <= CM_INIT;
      end else begin
         case (commState)
            CM_INIT: begin
               if (UVW_SUPPORTED && autoUvw && trackValid) begin
                  commState <= CM_UVW; // see [RL10]
               end else if (offsetValid) begin
                  commState <= CM_SINUS;
               end
            end
            CM_UVW: begin
               if (toSinus) begin
                  commState <= CM_SINUS; // see [RL12]
               end
            end
            CM_SINUS: commState <= CM_SINUS;
            default: commState <= CM_INIT;
         endcase
      end
   end

   assign uvwActive = (commState == CM_UVW); // see [RL13]
   assign motionEnable = driveEnable && (offsetValid || (measState == MS_RUN)
                         || (trimRequest == TRIM_REQUEST_ON) || uvwActive
                         || (commState == CM_SINUS)); // see [RL11]

   // ****************************************
   // Z-marker reference
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || measStart) begin
         zRefValid <= 1'b0;
         zRefAngle <= 16'h0000;
         zOffsetDeg <= 9'h000;
      end else if (zMarker && offsetValid && !zRefValid) begin
         zRefValid <= 1'b1;
         zRefAngle <= zAngle;
         zOffsetDeg <= degProduct[24:16]; // see [RL16]
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         angleSource <= ANGLE_SOURCE_RST;
      end else if (wrSource && (regWrData[7:0] <= SOURCE_ENCODER)) begin
         angleSource <= regWrData[7:0]; // see [RL1] [RL20]
      end
   end

   // Hardware alignments take priority over a software write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trim <= TRIM_RST;
      end else if (measDone) begin
         trim <= 16'h0000 - rawElec; // see [RL9]
      end else if (commState == CM_UVW && toSinus && switchMode != SWITCH_BY_BUS
                   && switchMode != SWITCH_AT_Z) begin
         trim <= sectorStart - rawElec;
      end else if ((commState == CM_UVW && toSinus && switchMode == SWITCH_AT_Z)
                   || zRefresh) begin
         trim <= zRefAngle - rawElec; // see [RL12]
      end else if (wrTrim) begin
         trim <= regWrData[15:0]; // see [RL5]
      end
   end

   // A write in the completion cycle wins over the clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trimRequest <= TRIM_REQUEST_RST;
      end else if (wrRequest) begin
         trimRequest <= regWrData[7:0];
      end else if (measDone) begin
         trimRequest <= TRIM_REQUEST_RST; // see [RL9]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         loopType <= LOOP_TYPE_RST;
      end else if (is_write(regAddr, ADDR_LOOP_TYPE, regWrite)) begin
         loopType <= regWrData; // see [RL7]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         poleCount <= POLE_COUNT_RST;
      end else if (pole_count_write) begin
         poleCount <= regWrData[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         posSource <= POS_SOURCE_RST;
      end else if (is_write(regAddr, ADDR_POS_SOURCE, regWrite)
                   && (regWrData[7:0] == POS_RESOLVER || regWrData[7:0] == POS_ENCODER)) begin
         posSource <= regWrData[7:0]; // see [RL17]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         autoUvw <= 1'b0;
         switchMode <= SWITCH_MODE_RST;
         zeroPattern <= UVW_ZERO_RST;
      end else if (wrUvw) begin
         autoUvw <= regWrData[UVW_AUTO_BIT];
         if (regWrData[UVW_MODE_LSB +: 3] >= SWITCH_AT_CHANGE
             && regWrData[UVW_MODE_LSB +: 3] <= SWITCH_BY_BUS) begin
            switchMode <= regWrData[UVW_MODE_LSB +: 3];
         end
         zeroPattern <= regWrData[UVW_ZERO_LSB +: 3];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busSwitch <= 1'b0;
      end else begin
         busSwitch <= is_write(regAddr, ADDR_SWITCH, regWrite) && regWrData[0];
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || !regRead) begin
         regRdData <= '0;
      end else begin
         case (regAddr)
            ADDR_ANGLE_SOURCE: regRdData <= 32'(angleSource);
            ADDR_TRIM: regRdData <= 32'(trim);
            ADDR_TRIM_REQUEST: regRdData <= 32'(trimRequest);
            ADDR_LOOP_TYPE: regRdData <= loopType;
            ADDR_POLE_COUNT: regRdData <= 32'(poleCount);
            ADDR_RESOLVER_ANGLE: regRdData <= 32'(resolverAngle);
            ADDR_ENCODER_ANGLE: regRdData <= 32'(encoderAngle);
            ADDR_POS_SOURCE: regRdData <= 32'(posSource);
            ADDR_UVW_CTRL: begin
               regRdData <= '0;
               regRdData[UVW_AUTO_BIT] <= autoUvw;
               regRdData[UVW_MODE_LSB +: 3] <= switchMode;
               regRdData[UVW_ZERO_LSB +: 3] <= zeroPattern;
            end
            ADDR_STATUS: begin
               regRdData <= '0;
               regRdData[ST_SINUS_BIT] <= (commState == CM_SINUS); // see [RL13]
               regRdData[ST_VALID_BIT] <= offsetValid;
               regRdData[ST_MEAS_BIT] <= (measState == MS_RUN);
               regRdData[ST_UVW_BIT] <= uvwActive;
               regRdData[ST_TRACK_LSB +: 3] <= track;
            end
            ADDR_Z_OFFSET: regRdData <= 32'(zOffsetDeg);
            default: regRdData <= '0;
         endcase
      end
   end

endmodule : rcas_commutation

//--- hw/rcas_pkg.sv
package rcas_pkg;

   // ****************************************
   // Register bus
   // ****************************************
   localparam int REG_ADDR_W = 4;
   localparam int REG_DATA_W = 32;
   localparam logic [3:0] ADDR_ANGLE_SOURCE = 4'h0;
   localparam logic [3:0] ADDR_TRIM = 4'h1;
   localparam logic [3:0] ADDR_TRIM_REQUEST = 4'h2;
   localparam logic [3:0] ADDR_LOOP_TYPE = 4'h3;
   localparam logic [3:0] ADDR_POLE_COUNT = 4'h4;
   localparam logic [3:0] ADDR_RESOLVER_ANGLE = 4'h5;
   localparam logic [3:0] ADDR_ENCODER_ANGLE = 4'h6;
   localparam logic [3:0] ADDR_POS_SOURCE = 4'h7;
   localparam logic [3:0] ADDR_UVW_CTRL = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'h9;
   localparam logic [3:0] ADDR_Z_OFFSET = 4'hA;
   localparam logic [3:0] ADDR_SWITCH = 4'hB;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [7:0] SOURCE_ZERO = 8'h00;
   localparam logic [7:0] SOURCE_RESOLVER = 8'h01;
   localparam logic [7:0] SOURCE_ENCODER = 8'h02;
   localparam logic [7:0] ANGLE_SOURCE_RST = 8'h02;
   localparam logic [15:0] TRIM_RST = 16'h1555;
   localparam logic [7:0] TRIM_REQUEST_RST = 8'h00;
   localparam logic [7:0] TRIM_REQUEST_ON = 8'h01;
   localparam logic [31:0] LOOP_TYPE_RST = 32'h00000000;
   localparam logic [15:0] POLE_COUNT_RST = 16'h000C;
   localparam logic [7:0] POS_SOURCE_RST = 8'h01;
   localparam logic [7:0] POS_RESOLVER = 8'h01;
   localparam logic [7:0] POS_ENCODER = 8'h02;

   // Transition modes, UVW to sinusoidal
   localparam logic [2:0] SWITCH_AT_CHANGE = 3'h1;
   localparam logic [2:0] SWITCH_AT_Z = 3'h2;
   localparam logic [2:0] SWITCH_CHANGE_Z = 3'h3;
   localparam logic [2:0] SWITCH_BY_BUS = 3'h4;
   localparam logic [2:0] SWITCH_MODE_RST = 3'h1;

   // UVW control fields: bit 0 auto, [6:4] mode, [10:8] zero pattern
   localparam int UVW_AUTO_BIT = 0;
   localparam int UVW_MODE_LSB = 4;
   localparam int UVW_ZERO_LSB = 8;
   localparam logic [2:0] UVW_ZERO_RST = 3'h1;
   // Status fields
   localparam int ST_SINUS_BIT = 0;
   localparam int ST_VALID_BIT = 1;
   localparam int ST_MEAS_BIT = 2;
   localparam int ST_UVW_BIT = 3;
   localparam int ST_TRACK_LSB = 4;

   // ****************************************
   // Angles and tracks
   // ****************************************
   localparam int SECTORS = 6;
   localparam logic [15:0] SECTOR_STEP = 16'h2AAB;
   localparam logic [15:0] HALF_SECTOR = 16'h1555;
   localparam logic [24:0] DEG_FULL = 25'h0000168;
   localparam logic [2:0] UVW_SEQ [SECTORS] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TRACK_PERIOD_NS = 2000000;
   localparam int TRACK_SAMPLE_CYCLES = TRACK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MEAS_TIME_NS = 2000000000;
   localparam int OFFSET_MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;

endpackage : rcas_pkg

//--- hw/rcas_track_sampler.sv
`timescale 1ns/1ps
module rcas_track_sampler #(
   parameter int unsigned PERIOD = rcas_pkg::TRACK_SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Track pins
   input wire logic [2:0] trackIn,
   // Sampled pattern
   output logic [2:0] sample,
   output logic sampleValid,
   output logic trackChange
);
   import rcas_pkg::*;

   localparam int CNT_W = $clog2(PERIOD);

   logic [CNT_W-1:0] tickCount;
   logic tick;

   assign tick = (tickCount == CNT_W'(PERIOD - 1));

   // ****************************************
   // Fixed-rate sample tick
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst || tick) begin
         tickCount <= '0;
      end else begin
         tickCount <= tickCount + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sample <= 3'h0;
         sampleValid <= 1'b0;
      end else if (tick) begin
         sample <= trackIn;
         sampleValid <= 1'b1;
      end
   end

   // Change only counts once a first sample exists
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trackChange <= 1'b0;
      end else begin
         trackChange <= tick && sampleValid && (trackIn != sample);
      end
   end

endmodule : rcas_track_sampler

//--- tb/rcas_commutation_props.sv
`timescale 1ns/1ps
module rcas_commutation_props (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [rcas_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [rcas_pkg::REG_DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [rcas_pkg::REG_DATA_W-1:0] regRdData,
   // Sensors and drive
   input wire logic [15:0] resolverAngle,
   input wire logic [15:0] encoderAngle,
   input wire logic driveEnable,
   input wire logic motionEnable,
   input wire logic [15:0] feedbackAngle,
   input wire logic [15:0] positionFeedback
);
   import rcas_pkg::*;
   logic [7:0] srcSel;
   logic [7:0] posSel;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ****
   // Selector shadows
   // ****
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         srcSel <= ANGLE_SOURCE_RST;
      end else if (regWrite && regAddr == ADDR_ANGLE_SOURCE && regWrData[7:0] < 8'h3) begin
         srcSel <= regWrData[7:0];
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         posSel <= POS_SOURCE_RST;
      end else if (regWrite && regAddr == ADDR_POS_SOURCE && regWrData[7:0] inside {1, 2}) begin
         posSel <= regWrData[7:0];
      end
   end
   // ****
   // Checks
   // ****
   zero_source_a:
   assert property (srcSel == SOURCE_ZERO |=> feedbackAngle == 16'h0)
      else $error("zero source angle not zero");
   resolver_source_a:
   assert property (srcSel == SOURCE_RESOLVER |=> feedbackAngle == $past(resolverAngle))
      else $error("resolver angle not followed");
   encoder_source_a:
   assert property (srcSel == SOURCE_ENCODER |=> feedbackAngle == $past(encoderAngle))
      else $error("encoder angle not followed");
   pos_encoder_a:
   assert property (posSel == POS_ENCODER |=> positionFeedback == $past(encoderAngle))
      else $error("position source not encoder");
   pos_resolver_a:
   assert property (posSel != POS_ENCODER |=> positionFeedback == $past(resolverAngle))
      else $error("position source not resolver");
   source_readback_a:
   assert property (regRead && regAddr == ADDR_ANGLE_SOURCE |=> regRdData == {24'h0, $past(srcSel)})
      else $error("source selector readback wrong");
   read_stands_a:
   assert property (!regRead |=> regRdData == 32'h0)
      else $error("read data outside its cycle");
   motion_gate_a:
   assert property (!driveEnable |-> !motionEnable)
      else $error("motion enabled without drive enable");
endmodule : rcas_commutation_props
bind rcas_commutation rcas_commutation_props i_rcas_commutation_props (.clk, .sys_rst,
   .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .resolverAngle, .encoderAngle,
   .driveEnable, .motionEnable, .feedbackAngle, .positionFeedback);

//--- tb/rcas_sensor_model.sv
`timescale 1ns/1ps
module rcas_sensor_model (
   // Clock and stimulus
   input wire logic clk,
   input wire logic [15:0] speed,
   input wire logic [2:0] pattern,
   input wire logic zReq,
   // Sensor front end
   output logic [15:0] resolverAngle,
   output logic [15:0] encoderAngle,
   output logic [2:0] trackUvw,
   output logic zMarker
);
   // ****
   // Shaft motion
   // ****
   initial begin
      resolverAngle = 16'h1234;
      encoderAngle = 16'hA5C3;
      trackUvw = 3'h1;
      zMarker = 1'h0;
   end
   always @(posedge clk) begin
      resolverAngle <= resolverAngle + speed;
      encoderAngle <= encoderAngle - speed;
      trackUvw <= pattern;
      zMarker <= zReq;
   end
endmodule : rcas_sensor_model

//--- tb/rotor_commutation_angle_select_test.sv
`timescale 1ns/1ps
module rotor_commutation_angle_select_test;
   import rcas_pkg::*;
   logic clk = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, driveEnable = 1'h0;
   logic zReq = 1'h0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic [15:0] speed = 16'h0;
   logic [2:0] pattern = 3'h1;
   logic [31:0] regRdData, rdVal;
   logic [15:0] resolverAngle, encoderAngle, feedbackAngle, phaseAngle, positionFeedback;
   logic [2:0] trackUvw;
   logic zMarker, motionEnable, uvwActive;
   int failures = 0, nTests = 0;
   int i, k, mSrc, mTrim, mPoles, mPos, mMode;
   rcas_commutation #(.TRACK_CYCLES(8), .MEAS_CYCLES(20)) i_rcas_commutation (.clk, .sys_rst,
      .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .resolverAngle, .encoderAngle,
      .trackUvw, .zMarker, .driveEnable, .motionEnable, .uvwActive, .feedbackAngle,
      .phaseAngle, .positionFeedback);
   rcas_sensor_model i_rcas_sensor_model (.clk, .speed, .pattern, .zReq, .resolverAngle,
      .encoderAngle, .trackUvw, .zMarker);
   always #5 clk = ~clk;
   // ****
   // Model and bus tasks
   // ****
   function automatic int expFb();
      return mSrc == 0 ? 0 : (mSrc == 1 ? resolverAngle : encoderAngle);
   endfunction : expFb
   function automatic int expPhase();
      return (expFb() * (mPoles / 2) + mTrim) % 32'h10000;
   endfunction : expPhase
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'h1;
      @(posedge clk);
      regWrite <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clk);
      regRead <= 1'h0;
      #1 rdVal = regRdData;
   endtask : rd
   task automatic waitUvw(input logic lvl);
      for (k = 0; k < 40 && uvwActive !== lvl; k++) @(posedge clk);
      chk("uvw active", lvl, uvwActive);
   endtask : waitUvw
   task automatic doReset();
      @(posedge clk);
      sys_rst <= 1'h1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'h0;
      mSrc = 2;
      mTrim = 32'h1555;
      mPoles = 12;
      mPos = 1;
      mMode = 1;
   endtask : doReset
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      give_verdict();
   end
   // ****
   // Scenarios
   // ****
   initial begin
      void'($urandom(32'h02e716c3));
      doReset();
      rd(ADDR_ANGLE_SOURCE);
      chk("source reset", 32'h2, rdVal);
      rd(ADDR_TRIM);
      chk("trim reset", 32'h1555, rdVal);
      rd(ADDR_POLE_COUNT);
      chk("poles reset", 32'hC, rdVal);
      rd(ADDR_POS_SOURCE);
      chk("pos reset", 32'h1, rdVal);
      wr(ADDR_RESOLVER_ANGLE, 32'h0);
      rd(ADDR_RESOLVER_ANGLE);
      chk("resolver read", resolverAngle, rdVal);
      rd(ADDR_ENCODER_ANGLE);
      chk("encoder read", encoderAngle, rdVal);
      rd(4'hF);
      chk("unmapped read", 32'h0, rdVal);
      for (i = 0; i < 16; i++) begin
         k = i < 4 ? i : $urandom_range(3);
         mPoles = 2 * $urandom_range(1, 8);
         mTrim = $urandom_range(32'hFFFF);
         speed <= 16'($urandom);
         @(posedge clk);
         speed <= 16'h0;
         wr(ADDR_ANGLE_SOURCE, k);
         mSrc = k < 3 ? k : mSrc;
         wr(ADDR_POLE_COUNT, mPoles);
         wr(ADDR_TRIM, mTrim);
         repeat (2) @(posedge clk);
         #1 chk("feedback angle", expFb(), feedbackAngle);
         chk("phase angle", expPhase(), phaseAngle);
      end
      for (i = 0; i < 4; i++) begin
         wr(ADDR_POS_SOURCE, i);
         mPos = (i == 1 || i == 2) ? i : mPos;
         repeat (2) @(posedge clk);
         #1 chk("position", mPos == 2 ? encoderAngle : resolverAngle, positionFeedback);
      end
      for (i = 1; i < 6; i++) begin
         wr(ADDR_UVW_CTRL, (i << 4) | 32'h100);
         mMode = i < 5 ? i : mMode;
         rd(ADDR_UVW_CTRL);
         chk("uvw mode", (mMode << 4) | 32'h100, rdVal);
      end
      wr(ADDR_ANGLE_SOURCE, 1);
      mSrc = 1;
      driveEnable <= 1'h1;
      repeat (2) @(posedge clk);
      #1 chk("motion gate", 1'h0, motionEnable);
      wr(ADDR_LOOP_TYPE, 32'h515);
      wr(ADDR_TRIM_REQUEST, 32'h1);
      rd(ADDR_LOOP_TYPE);
      chk("loop type", 32'h515, rdVal);
      rd(ADDR_STATUS);
      chk("no start", 1'h0, rdVal[ST_MEAS_BIT]);
      driveEnable <= 1'h0;
      @(posedge clk);
      driveEnable <= 1'h1;
      repeat (3) @(posedge clk);
      #1 chk("measure phase", 16'h0, phaseAngle);
      for (i = 0; i < 30; i++) begin
         rd(ADDR_TRIM_REQUEST);
         if (rdVal === 32'h0) break;
      end
      chk("request clear", 32'h0, rdVal);
      chk("measure time", 1'h1, i >= 8);
      mTrim = (32'h10000 - expFb() * (mPoles / 2) % 32'h10000) % 32'h10000;
      rd(ADDR_TRIM);
      chk("measured trim", mTrim, rdVal);
      rd(ADDR_STATUS);
      chk("offset valid", 1'h1, rdVal[ST_VALID_BIT]);
      chk("motion on", 1'h1, motionEnable);
      speed <= 16'($urandom);
      @(posedge clk);
      speed <= 16'h0;
      zReq <= 1'h1;
      @(posedge clk);
      zReq <= 1'h0;
      repeat (4) @(posedge clk);
      #1 chk("phase after trim", expPhase(), phaseAngle);
      rd(ADDR_Z_OFFSET);
      chk("z degrees", (expPhase() * 360) >> 16, rdVal);
      driveEnable <= 1'h0;
      doReset();
      pattern <= 3'h3;
      wr(ADDR_UVW_CTRL, 32'h111);
      waitUvw(1'h1);
      repeat (2) @(posedge clk);
      #1 chk("sector angle", 16'h4000, phaseAngle);
      rd(ADDR_STATUS);
      chk("status uvw", 32'h38, rdVal[6:0]);
      pattern <= 3'h2;
      waitUvw(1'h0);
      repeat (2) @(posedge clk);
      #1 chk("sinus start", 32'h5556, phaseAngle);
      doReset();
      wr(ADDR_UVW_CTRL, 32'h141);
      waitUvw(1'h1);
      pattern <= 3'h3;
      repeat (24) @(posedge clk);
      #1 chk("mode4 holds", 1'h1, uvwActive);
      wr(ADDR_SWITCH, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk("mode4 switch", 1'h0, uvwActive);
      give_verdict();
   end
endmodule : rotor_commutation_angle_select_test
